// ===== rtl/gbs_pkg.sv
// Package of constants for the GPIO bit-banged chip-select expander.
package gbs_pkg;

	// ----------------------------------------------------------------
	// Register reset values, SPI direction setting and GPIO bit positions
	// ----------------------------------------------------------------
	localparam logic [7:0] GBS_DIR_RST   = 8'h00;
	localparam logic [7:0] GBS_OUT_RST   = 8'h00;
	localparam logic [7:0] GBS_DIR_SPI   = 8'h0c;
	localparam int         GBS_BIT_STORE = 0;
	localparam int         GBS_BIT_OE    = 1;
	localparam int         GBS_BIT_SCLK  = 2;
	localparam int         GBS_BIT_MOSI  = 3;

	// ----------------------------------------------------------------
	// One-hot select codes and shift register reset value
	// ----------------------------------------------------------------
	localparam logic [7:0] GBS_SEL_TOP   = 8'h01;
	localparam logic [7:0] GBS_SEL_MID   = 8'h02;
	localparam logic [7:0] GBS_SEL_BOT   = 8'h04;
	localparam logic [7:0] GBS_SEL_DAC   = 8'h08;
	localparam logic [7:0] GBS_SR_RST    = 8'h00;

	// ----------------------------------------------------------------
	// Isolator defaults
	// ----------------------------------------------------------------
	localparam logic       GBS_ISO_RST   = 1'b0;

endpackage

// ===== rtl/gbs_shift_latch.sv
// Eight-bit serial-in shift register with output latch and tri-state enable.
`timescale 1ns/100ps
module gbs_shift_latch
	import gbs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       sclk_rise,
	input  wire logic       sdata,
	input  wire logic       store_rise,
	input  wire logic       oe,
	output logic [7:0]      shift_q,
	output logic [7:0]      sel_q,
	output logic [7:0]      sel_oe_q
);

	// ----------------------------------------------------------------
	// Shift stage
	// ----------------------------------------------------------------
	// Data enters at bit 0 so the first bit sent ends in bit 7.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			shift_q <= GBS_SR_RST;
		else if (sclk_rise)
			shift_q <= {shift_q[6:0], sdata};
	end

	// ----------------------------------------------------------------
	// Output latch and enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sel_q <= GBS_SR_RST;
		else if (store_rise)
			sel_q <= shift_q;
	end

	// Outputs float when not enabled; the enable per line stands for the driver.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sel_oe_q <= 8'h00;
		else
			sel_oe_q <= {8{oe}};
	end

endmodule

// ===== rtl/gbs_top.sv
// GPIO register pair driving a shift-register chip-select expander and SPI lines.
//
// Contract
// - Setting output bit 0 copies the shift contents into the output latch.
// - Setting output bit 1 enables the latch onto the chip-select lines.
// - Expander is eight-bit shift register, separate latch, floating outputs.
// - Isolated gate and clamp outputs default low when unpowered.
`timescale 1ns/100ps
module gbs_top
	import gbs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       dir_wr,
	input  wire logic       out_wr,
	input  wire logic [7:0] wr_data,
	output logic [7:0]      gpio_direction_ff,
	output logic [7:0]      gpio_output_levels_ff,
	output logic [7:0]      gpio_pin_ff,
	output logic            spi_sclk_ff,
	output logic            spi_mosi_ff,
	output logic [7:0]      chip_sel_ff,
	output logic [7:0]      chip_sel_oe_ff,
	input  wire logic       iso_powered,
	input  wire logic       gate_in,
	input  wire logic       clamp_in,
	output logic            primary_switch_gate_ff,
	output logic            clamp_gate_ff
);

	logic [7:0] shift_q;
	logic [7:0] sel_q;
	logic [7:0] sel_oe_q;
	logic [7:0] nxt_pin;
	logic       sclk_rise;
	logic       store_rise;
	logic [7:0] gpio_pin_prev_ff;
	logic [2:0] iso_s1_ff;
	logic [2:0] iso_s2_ff;

	// ----------------------------------------------------------------
	// GPIO registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			gpio_direction_ff <= GBS_DIR_RST;
		else if (dir_wr)
			gpio_direction_ff <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			gpio_output_levels_ff <= GBS_OUT_RST;
		else if (out_wr)
			gpio_output_levels_ff <= wr_data;
	end

	// Only lines set as outputs drive; an input line reads low here.
	assign nxt_pin = gpio_output_levels_ff & gpio_direction_ff;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			gpio_pin_ff <= GBS_OUT_RST;
		else
			gpio_pin_ff <= nxt_pin;
	end

	// ----------------------------------------------------------------
	// Pin edge detection
	// ----------------------------------------------------------------
	// Edges compare the registered pins with their previous cycle, so the shift
	// stage samples the same data level that the pins show at the clock rise.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			gpio_pin_prev_ff <= GBS_OUT_RST;
		else
			gpio_pin_prev_ff <= gpio_pin_ff;
	end

	assign sclk_rise  = gpio_pin_ff[GBS_BIT_SCLK] & ~gpio_pin_prev_ff[GBS_BIT_SCLK];
	assign store_rise = gpio_pin_ff[GBS_BIT_STORE] & ~gpio_pin_prev_ff[GBS_BIT_STORE];

	// ----------------------------------------------------------------
	// Expander
	// ----------------------------------------------------------------
	gbs_shift_latch u_sr (
		.clk        (clk),
		.rst_n      (rst_n),
		.sclk_rise  (sclk_rise),
		.sdata      (gpio_pin_ff[GBS_BIT_MOSI]),
		.store_rise (store_rise),
		.oe         (gpio_pin_ff[GBS_BIT_OE]),
		.shift_q    (shift_q),
		.sel_q      (sel_q),
		.sel_oe_q   (sel_oe_q)
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			spi_sclk_ff    <= 1'b0;
			spi_mosi_ff    <= 1'b0;
			chip_sel_ff    <= GBS_SR_RST;
			chip_sel_oe_ff <= 8'h00;
		end
		else
		begin
			spi_sclk_ff    <= gpio_pin_ff[GBS_BIT_SCLK];
			spi_mosi_ff    <= gpio_pin_ff[GBS_BIT_MOSI];
			chip_sel_ff    <= sel_q & sel_oe_q;
			chip_sel_oe_ff <= sel_oe_q;
		end
	end

	// ----------------------------------------------------------------
	// Isolated gate path
	// ----------------------------------------------------------------
	// Pins from the isolator are synchronised before use.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			iso_s1_ff <= 3'h0;
			iso_s2_ff <= 3'h0;
		end
		else
		begin
			iso_s1_ff <= {iso_powered, gate_in, clamp_in};
			iso_s2_ff <= iso_s1_ff;
		end
	end

	// Unpowered input side forces both gates low, so the FETs stay off.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			primary_switch_gate_ff <= GBS_ISO_RST;
			clamp_gate_ff          <= GBS_ISO_RST;
		end
		else
		begin
			primary_switch_gate_ff <= iso_s2_ff[2] & iso_s2_ff[1];
			clamp_gate_ff          <= iso_s2_ff[2] & iso_s2_ff[0];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_SHIFT_ON_RISE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(gpio_pin_ff[GBS_BIT_SCLK]) |=> shift_q[0] == $past(gpio_pin_ff[GBS_BIT_MOSI]))
		else $error("shift stage missed data on clock rise");

	AST_SHIFT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!$rose(gpio_pin_ff[GBS_BIT_SCLK]) |=> $stable(shift_q))
		else $error("shift stage moved without clock rise");

	AST_STORE_COPY: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(gpio_pin_ff[GBS_BIT_STORE]) |=> sel_q == $past(shift_q))
		else $error("latch did not take shift contents");

	AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!$rose(gpio_pin_ff[GBS_BIT_STORE]) |=> $stable(sel_q))
		else $error("latch changed without store edge");

	AST_SEL_GATED: assert property (@(posedge clk) disable iff (!rst_n)
		!gpio_pin_ff[GBS_BIT_OE] |-> ##2 chip_sel_ff == 8'h00 && chip_sel_oe_ff == 8'h00)
		else $error("chip select active without enable");

	AST_SEL_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
		gpio_pin_ff[GBS_BIT_OE] ##1 gpio_pin_ff[GBS_BIT_OE] |=> chip_sel_ff == $past(sel_q)
		&& chip_sel_oe_ff == 8'hff)
		else $error("enabled latch not on select lines");

	AST_ISO_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		!iso_s2_ff[2] |=> !primary_switch_gate_ff && !clamp_gate_ff)
		else $error("isolated gate high while unpowered");

	AST_PIN_MASK: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (gpio_pin_ff & ~$past(gpio_direction_ff)) == 8'h00)
		else $error("input line driven as output");

	AST_SHIFT_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(gpio_pin_ff[GBS_BIT_SCLK]) |=> shift_q[7:1] == $past(shift_q[6:0]))
		else $error("shift stage lost bit order");

	AST_SEL_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
		(chip_sel_ff & ~chip_sel_oe_ff) == 8'h00)
		else $error("select line high while floating");

	AST_OE_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
		gpio_pin_ff[GBS_BIT_OE] |=> ##1 chip_sel_oe_ff == 8'hff)
		else $error("select outputs not enabled after enable pin");

	AST_OE_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
		!gpio_pin_ff[GBS_BIT_OE] |=> sel_oe_q == 8'h00)
		else $error("expander outputs driven without enable");

	AST_GATE_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
		iso_s2_ff[2] |=> primary_switch_gate_ff == $past(iso_s2_ff[1])
		&& clamp_gate_ff == $past(iso_s2_ff[0]))
		else $error("isolated gate does not follow its input");

	AST_GATE_IN_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		!iso_s2_ff[1] |=> !primary_switch_gate_ff)
		else $error("primary gate high with its input low");

endmodule

// ===== bench/gbs_slave_model.sv
// Behavioural SPI target that records each byte clocked to the selected chip.
`timescale 1ns/100ps
module gbs_slave_model
(
	input  wire logic       clk,
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic [7:0] sel,
	output logic            rx_valid,
	output logic [7:0]      rx_sel,
	output logic [7:0]      rx_byte
);
	logic       sclk_ff = 1'b0;
	logic [7:0] sh_ff   = 8'h00;
	int         cnt     = 0;

	// A target ignores the clock while deselected, so stray edges do not count.
	always @(posedge clk)
	begin
		rx_valid <= 1'b0;
		sclk_ff  <= sclk;
		if (sel == 8'h00)
			cnt <= 0;
		else if (sclk && !sclk_ff)
		begin
			sh_ff <= {sh_ff[6:0], mosi};
			cnt   <= (cnt == 7) ? 0 : cnt + 1;
			if (cnt == 7)
			begin
				rx_valid <= 1'b1;
				rx_byte  <= {sh_ff[6:0], mosi};
				rx_sel   <= sel;
			end
		end
	end
endmodule

// ===== bench/gbs_top_tb.sv
// Self-checking bench for the GPIO bit-banged chip-select expander.
`timescale 1ns/100ps
module gbs_top_tb
	import gbs_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        dir_wr = 1'b0;
	logic        out_wr = 1'b0;
	logic [7:0]  wr_data = 8'h00;
	logic        iso_powered = 1'b0;
	logic        gate_in = 1'b0;
	logic        clamp_in = 1'b0;
	logic [7:0]  gpio_direction_ff, gpio_output_levels_ff, gpio_pin_ff;
	logic [7:0]  chip_sel_ff, chip_sel_oe_ff, rx_sel, rx_byte, cmd;
	logic        spi_sclk_ff, spi_mosi_ff, primary_switch_gate_ff, clamp_gate_ff, rx_valid;
	logic [7:0]  codes[4] = '{GBS_SEL_TOP, GBS_SEL_MID, GBS_SEL_BOT, GBS_SEL_DAC};
	logic [15:0] exp_q[$];
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #10 clk = ~clk;

	gbs_top u_dut (.clk, .rst_n, .dir_wr, .out_wr, .wr_data, .gpio_direction_ff,
		.gpio_output_levels_ff, .gpio_pin_ff, .spi_sclk_ff, .spi_mosi_ff, .chip_sel_ff,
		.chip_sel_oe_ff, .iso_powered, .gate_in, .clamp_in, .primary_switch_gate_ff,
		.clamp_gate_ff);
	gbs_slave_model u_slave (.clk, .sclk(spi_sclk_ff), .mosi(spi_mosi_ff),
		.sel(chip_sel_ff), .rx_valid, .rx_sel, .rx_byte);

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic chk_rx(logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED rx exp %h got %h", exp, got);
		end
	endtask

	task automatic idle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Each write waits out the pin, shift and latch pipeline before the next.
	task automatic wr(logic dir, logic [7:0] d);
		dir_wr  = dir;
		out_wr  = ~dir;
		wr_data = d;
		idle(1);
		dir_wr = 1'b0;
		out_wr = 1'b0;
		idle(5);
	endtask

	task automatic shift_byte(logic [7:0] b, logic [1:0] ctl);
		for (int i = 7; i >= 0; i--)
		begin
			wr(1'b0, {4'h0, b[i], 1'b0, ctl});
			wr(1'b0, {4'h0, b[i], 1'b1, ctl});
		end
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (rx_valid === 1'b1)
			chk_rx(exp_q.pop_front(), {rx_sel, rx_byte});
		if (cycles == 5000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(79647));
		idle(5);
		rst_n = 1'b1;
		chk8("dir", GBS_DIR_RST, gpio_direction_ff);
		chk8("cs", 8'h00, chip_sel_ff);
		$display("test reset done");
		wr(1'b0, 8'h0c);
		chk8("pin", 8'h00, gpio_pin_ff);
		chk8("out", 8'h0c, gpio_output_levels_ff);
		wr(1'b1, GBS_DIR_SPI);
		chk8("pin", 8'h0c, gpio_pin_ff);
		chk8("dir", GBS_DIR_SPI, gpio_direction_ff);
		wr(1'b0, 8'h00);
		wr(1'b1, 8'h0f);
		$display("test direction done");
		for (int k = 0; k < 4; k++)
		begin
			cmd = 8'($urandom);
			shift_byte(codes[k], 2'b00);
			wr(1'b0, 8'h01);
			chk8("cs", 8'h00, chip_sel_ff);
			wr(1'b0, 8'h03);
			chk8("cs", codes[k], chip_sel_ff);
			chk8("oe", 8'hff, chip_sel_oe_ff);
			chk8("onehot", 8'h01, 8'($countones(chip_sel_ff)));
			exp_q.push_back({codes[k], cmd});
			shift_byte(cmd, 2'b11);
			chk8("cs", codes[k], chip_sel_ff);
			chk8("sclk", 8'h01, {7'h00, spi_sclk_ff});
			chk8("mosi", {7'h00, cmd[0]}, {7'h00, spi_mosi_ff});
			wr(1'b0, 8'h00);
			chk8("cs", 8'h00, chip_sel_ff);
			$display("test select %h done", codes[k]);
		end
		gate_in  = 1'b1;
		clamp_in = 1'b1;
		idle(6);
		chk8("gate", 8'h00, {6'h00, primary_switch_gate_ff, clamp_gate_ff});
		iso_powered = 1'b1;
		idle(6);
		chk8("gate", 8'h03, {6'h00, primary_switch_gate_ff, clamp_gate_ff});
		$display("test isolator done");
		stop_test();
	end
endmodule
